/* File: logic/usr_regs.svh */
// register offsets, field positions, reset values for the serial transceiver
`ifndef USR_REGS_SVH
`define USR_REGS_SVH
`define USR_DATA_OFS 8'hEC
`define USR_CTRL_OFS 8'hED
`define USR_CS_BASE 6'h3B
// mode word fields
`define USR_MD_FAC 1:0
`define USR_MD_LEN 3:2
`define USR_MD_PEN 4
`define USR_MD_EVEN 5
`define USR_MD_STOP 7:6
`define USR_MD_EXTS 6
`define USR_MD_ONES 7
`define USR_MODE_RST 8'h00
// command word fields
`define USR_CM_TXA 0
`define USR_CM_DTR 1
`define USR_CM_RXE 2
`define USR_CM_BRK 3
`define USR_CM_ERR 4
`define USR_CM_RTS 5
`define USR_CM_IRST 6
`define USR_CM_SYNC_SEARCH_STATE 7
`define USR_CMD_RST 8'h00
// status byte fields
`define USR_ST_TXF 0
`define USR_ST_RXW 1
`define USR_ST_DRN 2
`define USR_ST_PE 3
`define USR_ST_OE 4
`define USR_ST_FE 5
`define USR_ST_SYN 6
`define USR_ST_DSR 7
`endif

/* File: logic/usr_pkg.sv */
// types for the serial transceiver
package usr_pkg;
    typedef enum logic [1:0] {CW_MODE, CW_SYNC1, CW_SYNC2, CW_CMD} usr_ctl_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_SYNC_SEARCH_STATE} usr_rx_t;
endpackage

/* File: logic/usr_usart.sv */
// serial transceiver with host port, async/sync transmitter and receiver
`timescale 1ns/1ns
`include "usr_regs.svh"

// Function
// - after mode and sync characters, every control write is a command word
// - internal or external reset returns to expecting a mode word
// - status byte is readable with control select high at any time
// - slot-free output high when a character fits while transmit-allow is set and clear-to-send low, cleared by a data write
// - character-waiting output raised on complete character, cleared by data read
// - transmission starts only with transmit-allow set and clear-to-send low
// - reset holds the transmit line high
// - async frame is start low, data, optional parity, programmed stop bits
// - bits leave on falling transmit clock edges, divided by 1, 16 or 64
// - idle line stays high; break holds it continuously low
// - at factor 16 or 64, falling edge starts start-bit check at centre; accept only if still low
// - bit counter finds bit centres; sampling on rising receive clock edges
// - parity mismatch sets the parity error flag
// - low stop bit sets framing error; character still loaded
// - unread character is overwritten and the overrun flag set
// - command word with bit 4 set clears error flags; errors never stop operation
// - sync transmit idles high until the first character, then sends on clear-to-send
// - empty sync transmitter inserts sync characters and raises drained until next write
// - internal-sync receive hunts for one or two sync characters, flags sync found
// - sync receiver checks parity and overrun as async does
// - a command with bit 7 set sends the internal-sync receiver back to sync search
// - chip select for addresses EC to EF; address bit zero picks control or data
// - transmit-allow is command bit 0; clearing it disables transmitter indications
// - two lowest mode bits choose sync or async and the meaning of the rest
module usr_usart (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] io_addr_i,
    input wire logic io_write_n_i,
    input wire logic io_read_n_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    input wire logic tx_bit_clock_i,
    input wire logic rx_bit_clock_i,
    input wire logic rxd_i,
    output logic txd_o,
    input wire logic cts_n_i,
    input wire logic dsr_n_i,
    output logic dtr_n_o,
    output logic rts_n_o,
    output logic tx_slot_free_o,
    output logic rx_char_waiting_o,
    output logic tx_drained_o,
    output logic sync_found_o
);
    import usr_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] ch_len(input logic [7:0] m);
        return 4'd5 + {2'b00, m[`USR_MD_LEN]};
    endfunction
    function automatic logic [6:0] fac(input logic [7:0] m);
        return (m[`USR_MD_FAC] == 2'b10) ? 7'd16 : ((m[`USR_MD_FAC] == 2'b11) ? 7'd64 : 7'd1);
    endfunction
    function automatic logic [7:0] mask(input logic [3:0] n);
        return 8'hFF >> (4'd8 - n);
    endfunction
    // right-align the last k bits shifted into a 9-bit assembler
    function automatic logic [8:0] align(input logic [8:0] v, input logic [3:0] k);
        return v >> (4'd9 - k);
    endfunction
    // frame: {bit count, bits lsb first}; sync frames put data where the start bit sits
    function automatic logic [15:0] mk_frame(input logic [7:0] d, input logic [7:0] m);
        logic [11:0] fr;
        int pos;
        logic [3:0] n;
        fr = 12'hFFE;
        n = ch_len(m);
        pos = (m[`USR_MD_FAC] == 2'b00) ? 0 : 1;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(n)) fr[pos + i] = d[i];
        end
        pos = pos + int'(n);
        if (m[`USR_MD_PEN]) begin
            fr[pos] = ^(d & mask(n)) ^ ~m[`USR_MD_EVEN];
            pos = pos + 1;
        end
        if (m[`USR_MD_FAC] != 2'b00) pos = pos + ((m[`USR_MD_STOP] == 2'b11) ? 2 : 1);
        return {4'(pos), fr};
    endfunction
    // ------------------------------------------------------------
    // host port decode
    // ------------------------------------------------------------
    logic cs, wr_prev_q, rd_prev_q, wr_ev, rd_ev;
    logic ctl_wr, dat_wr, st_rd, dat_rd;
    assign cs = (io_addr_i[7:2] == `USR_CS_BASE);
    assign wr_ev = cs && !io_write_n_i && wr_prev_q;
    assign rd_ev = cs && !io_read_n_i && rd_prev_q;
    assign ctl_wr = wr_ev && io_addr_i[0];
    assign dat_wr = wr_ev && !io_addr_i[0];
    assign st_rd = rd_ev && io_addr_i[0];
    assign dat_rd = rd_ev && !io_addr_i[0];
    assign data_oe_o = cs && !io_read_n_i;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
        end else begin
            wr_prev_q <= io_write_n_i;
            rd_prev_q <= io_read_n_i;
        end
    end
    // ------------------------------------------------------------
    // control word sequencing
    // ------------------------------------------------------------
    usr_ctl_t ctl_q;
    logic [7:0] mode_q, cmd_q, sync1_q, sync2_q;
    logic snc_md, irst;
    assign snc_md = (mode_q[`USR_MD_FAC] == 2'b00);
    assign irst = ctl_wr && (ctl_q == CW_CMD) && data_i[`USR_CM_IRST];
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctl_q <= CW_MODE;
            mode_q <= `USR_MODE_RST;
            cmd_q <= `USR_CMD_RST;
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end else if (ctl_wr) begin
            unique case (ctl_q)
                CW_MODE: begin
                    mode_q <= data_i;
                    ctl_q <= (data_i[`USR_MD_FAC] == 2'b00) ? CW_SYNC1 : CW_CMD;
                end
                CW_SYNC1: begin
                    sync1_q <= data_i;
                    ctl_q <= mode_q[`USR_MD_ONES] ? CW_CMD : CW_SYNC2;
                end
                CW_SYNC2: begin
                    sync2_q <= data_i;
                    ctl_q <= CW_CMD;
                end
                CW_CMD: begin
                    cmd_q <= data_i[`USR_CM_IRST] ? `USR_CMD_RST : data_i;
                    if (data_i[`USR_CM_IRST]) ctl_q <= CW_MODE;
                end
            endcase
        end
    end
    assign dtr_n_o = ~cmd_q[`USR_CM_DTR];
    assign rts_n_o = ~cmd_q[`USR_CM_RTS];

    // ------------------------------------------------------------
    // bit clock edges
    // ------------------------------------------------------------
    logic txclk_q, rxclk_q, tx_tick, rx_tick;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            txclk_q <= 1'b1;
            rxclk_q <= 1'b1;
        end else begin
            txclk_q <= tx_bit_clock_i;
            rxclk_q <= rx_bit_clock_i;
        end
    end
    assign tx_tick = txclk_q && !tx_bit_clock_i;
    assign rx_tick = !rxclk_q && rx_bit_clock_i;

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    logic [7:0] thr_q;
    logic thr_full_q, tbusy_q, tstart_q, fill2_q, drained_q, txd_q;
    logic [11:0] tsh_q;
    logic [3:0] tbits_q;
    logic [6:0] tcnt_q;
    logic tx_go, ld_data, ld_fill, tdone;
    logic [15:0] fr_d;
    logic [6:0] blen;
    assign tx_go = cmd_q[`USR_CM_TXA] && !cts_n_i;
    assign ld_data = tx_go && !tbusy_q && thr_full_q;
    assign ld_fill = tx_go && !tbusy_q && !thr_full_q && snc_md && tstart_q;
    assign fr_d = mk_frame(ld_data ? thr_q : (fill2_q ? sync2_q : sync1_q), mode_q);
    assign tdone = tx_tick && tbusy_q && tcnt_q == 7'd0 && tbits_q == 4'd0;
    // last stop bit of a one-and-a-half stop frame runs half a bit longer
    assign blen = (tbits_q == 4'd1 && !snc_md && mode_q[`USR_MD_STOP] == 2'b10)
        ? fac(mode_q) + (fac(mode_q) >> 1) : fac(mode_q);
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            thr_q <= 8'h00;
            thr_full_q <= 1'b0;
        end else begin
            if (dat_wr) thr_q <= data_i;
            if (dat_wr) thr_full_q <= 1'b1;
            else if (ld_data || irst) thr_full_q <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tbusy_q <= 1'b0;
            tsh_q <= 12'hFFF;
            tbits_q <= 4'd0;
            tcnt_q <= 7'd0;
            txd_q <= 1'b1;
        end else if (irst) begin
            tbusy_q <= 1'b0;
            txd_q <= 1'b1;
        end else if (ld_data || ld_fill) begin
            tbusy_q <= 1'b1;
            tsh_q <= fr_d[11:0];
            tbits_q <= fr_d[15:12];
            tcnt_q <= 7'd0;
        end else if (tdone) begin
            tbusy_q <= 1'b0;
        end else if (tx_tick && tbusy_q) begin
            if (tcnt_q == 7'd0) begin
                txd_q <= tsh_q[0];
                tsh_q <= {1'b1, tsh_q[11:1]};
                tbits_q <= tbits_q - 4'd1;
                tcnt_q <= blen - 7'd1;
            end else begin
                tcnt_q <= tcnt_q - 7'd1;
            end
        end
    end
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tstart_q <= 1'b0;
            fill2_q <= 1'b0;
            drained_q <= 1'b1;
        end else begin
            if (irst) tstart_q <= 1'b0;
            else if (ld_data && snc_md) tstart_q <= 1'b1;
            if (ld_fill) fill2_q <= !mode_q[`USR_MD_ONES] && !fill2_q;
            else if (ld_data) fill2_q <= 1'b0;
            if (ld_fill || (!snc_md && !tbusy_q && !thr_full_q && !dat_wr)) drained_q <= 1'b1;
            else if (dat_wr) drained_q <= 1'b0;
        end
    end
    assign txd_o = cmd_q[`USR_CM_BRK] ? 1'b0 : txd_q;
    assign tx_slot_free_o = tx_go && !thr_full_q;
    assign tx_drained_o = cmd_q[`USR_CM_TXA] && drained_q;

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    usr_rx_t rx_q;
    logic [6:0] rcnt_q, half;
    logic [3:0] rbits_q, rlen, nbits;
    logic [8:0] rsh_q, nsh, word;
    logic rprev_q, hunt2_q, rxw_q, pe_q, oe_q, fe_q, sf_q;
    logic [7:0] rbuf_q;
    logic samp, rdone, hmatch, pbad, idle_sync_search_state;
    assign rlen = ch_len(mode_q);
    assign nbits = rlen + {3'b000, mode_q[`USR_MD_PEN]};
    assign half = fac(mode_q) >> 1;
    assign nsh = {rxd_i, rsh_q[8:1]};
    assign samp = rx_tick && rx_q == RX_BITS && rcnt_q == 7'd0;
    // sync characters end on their last bit, async ones on the stop bit
    assign rdone = samp && (snc_md ? rbits_q == 4'd1 : rbits_q == 4'd0);
    assign word = align(snc_md ? nsh : rsh_q, nbits);
    assign pbad = mode_q[`USR_MD_PEN] && ((^(word[7:0] & mask(rlen)) ^ ~mode_q[`USR_MD_EVEN]) != word[rlen]);
    assign hmatch = (align(nsh, rlen) & {1'b0, mask(rlen)}) == {1'b0, sync1_q & mask(rlen)};
    assign idle_sync_search_state = snc_md && !mode_q[`USR_MD_EXTS];
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_q <= RX_IDLE;
            rcnt_q <= 7'd0;
            rbits_q <= 4'd0;
            rsh_q <= 9'h000;
            rprev_q <= 1'b1;
            hunt2_q <= 1'b0;
        end else if (!cmd_q[`USR_CM_RXE] || ctl_q != CW_CMD) begin
            rx_q <= idle_sync_search_state ? RX_SYNC_SEARCH_STATE : (snc_md ? RX_BITS : RX_IDLE);
            rbits_q <= nbits;
            rcnt_q <= 7'd0;
            hunt2_q <= 1'b0;
        end else if (ctl_wr && data_i[`USR_CM_SYNC_SEARCH_STATE] && idle_sync_search_state) begin
            rx_q <= RX_SYNC_SEARCH_STATE;
            hunt2_q <= 1'b0;
        end else if (rx_tick) begin
            rprev_q <= rxd_i;
            unique case (rx_q)
                RX_IDLE: if (rprev_q && !rxd_i) begin
                    rx_q <= (half == 7'd0) ? RX_BITS : RX_START;
                    rcnt_q <= (half == 7'd0) ? 7'd0 : half - 7'd1;
                    rbits_q <= nbits;
                end
                RX_START: if (rcnt_q != 7'd0) rcnt_q <= rcnt_q - 7'd1;
                    else if (rxd_i) rx_q <= RX_IDLE;
                    else begin
                        rx_q <= RX_BITS;
                        rcnt_q <= fac(mode_q) - 7'd1;
                    end
                RX_BITS: if (rcnt_q != 7'd0) rcnt_q <= rcnt_q - 7'd1;
                    else begin
                        rcnt_q <= fac(mode_q) - 7'd1;
                        if (rbits_q != 4'd0) rsh_q <= nsh;
                        if (rdone) begin
                            rbits_q <= nbits;
                            if (!snc_md) rx_q <= RX_IDLE;
                            else if (hunt2_q) begin
                                hunt2_q <= 1'b0;
                                if ((word[7:0] & mask(rlen)) != (sync2_q & mask(rlen))) rx_q <= RX_SYNC_SEARCH_STATE;
                            end
                        end else begin
                            rbits_q <= rbits_q - 4'd1;
                        end
                    end
                RX_SYNC_SEARCH_STATE: begin
                    rsh_q <= nsh;
                    if (hmatch) begin
                        rx_q <= RX_BITS;
                        rcnt_q <= 7'd0;
                        rbits_q <= nbits;
                        hunt2_q <= !mode_q[`USR_MD_ONES];
                    end
                end
            endcase
        end
    end
    logic sync_search_state_hit, rx_load;
    assign sync_search_state_hit = rx_tick && cmd_q[`USR_CM_RXE] && ctl_q == CW_CMD && rx_q == RX_SYNC_SEARCH_STATE && hmatch;
    assign rx_load = rdone && !hunt2_q && cmd_q[`USR_CM_RXE] && ctl_q == CW_CMD;
    // flags: a hardware set in the same cycle as its clear wins
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rbuf_q <= 8'h00;
            rxw_q <= 1'b0;
            pe_q <= 1'b0;
            oe_q <= 1'b0;
            fe_q <= 1'b0;
            sf_q <= 1'b0;
        end else begin
            if (rx_load) rbuf_q <= word[7:0] & mask(rlen);
            if (rx_load) rxw_q <= 1'b1;
            else if (dat_rd) rxw_q <= 1'b0;
            if (rx_load && pbad) pe_q <= 1'b1;
            else if (ctl_wr && ctl_q == CW_CMD && data_i[`USR_CM_ERR]) pe_q <= 1'b0;
            if (rx_load && rxw_q && !dat_rd) oe_q <= 1'b1;
            else if (ctl_wr && ctl_q == CW_CMD && data_i[`USR_CM_ERR]) oe_q <= 1'b0;
            if (rx_load && !snc_md && !rxd_i) fe_q <= 1'b1;
            else if (ctl_wr && ctl_q == CW_CMD && data_i[`USR_CM_ERR]) fe_q <= 1'b0;
            if ((sync_search_state_hit && mode_q[`USR_MD_ONES]) || (rdone && hunt2_q && rx_q == RX_BITS
                && (word[7:0] & mask(rlen)) == (sync2_q & mask(rlen)))) sf_q <= 1'b1;
            else if (st_rd) sf_q <= 1'b0;
        end
    end
    assign rx_char_waiting_o = rxw_q && cmd_q[`USR_CM_RXE];
    assign sync_found_o = sf_q;
    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [7:0] stat;
    always_comb begin
        stat = 8'h00;
        stat[`USR_ST_TXF] = tx_slot_free_o;
        stat[`USR_ST_RXW] = rx_char_waiting_o;
        stat[`USR_ST_DRN] = tx_drained_o;
        stat[`USR_ST_PE] = pe_q;
        stat[`USR_ST_OE] = oe_q;
        stat[`USR_ST_FE] = fe_q;
        stat[`USR_ST_SYN] = sf_q;
        stat[`USR_ST_DSR] = !dsr_n_i;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) data_o <= 8'h00;
        else if (rd_ev) data_o <= io_addr_i[0] ? stat : rbuf_q;
    end
endmodule // usr_usart

/* File: tb/usr_usart_assertions.sv */
// checker of host-port and modem-line relations of the serial transceiver
`timescale 1ns/1ns
module usr_usart_assertions (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] io_addr_i,
    input wire logic io_write_n_i,
    input wire logic io_read_n_i,
    input wire logic cts_n_i,
    input wire logic dsr_n_i,
    input logic [7:0] data_o,
    input logic data_oe_o,
    input logic dtr_n_o,
    input logic rts_n_o,
    input logic tx_slot_free_o,
    input logic rx_char_waiting_o,
    input logic tx_drained_o,
    input logic sync_found_o
);
    // ----------------------------------------
    // access detection
    // ----------------------------------------
    logic rd_q;
    logic wr_q;
    logic sel;
    logic rd_take;
    logic wr_take;
    assign sel = io_addr_i[7:2] == 6'h3B;
    assign rd_take = sel && !io_read_n_i && rd_q;
    assign wr_take = sel && !io_write_n_i && wr_q;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_q <= 1'h1;
            wr_q <= 1'h1;
        end else begin
            rd_q <= io_read_n_i;
            wr_q <= io_write_n_i;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_oe; data_oe_o == (sel && !io_read_n_i); endproperty
    a_oe: assert property (p_oe) else $error("read enable wrong");
    property p_cts; tx_slot_free_o |-> !cts_n_i; endproperty
    a_cts: assert property (p_cts) else $error("slot free without clear to send");
    property p_slot; wr_take && !io_addr_i[0] |=> !tx_slot_free_o; endproperty
    a_slot: assert property (p_slot) else $error("slot free kept after data write");
    property p_rxclr; rd_take && !io_addr_i[0] |-> ##1 !rx_char_waiting_o; endproperty
    a_rxclr: assert property (p_rxclr) else $error("waiting kept after data read");
    property p_synclr; rd_take && io_addr_i[0] |=> !sync_found_o; endproperty
    a_synclr: assert property (p_synclr) else $error("sync found kept after status read");
    property p_dout; $changed(data_o) |-> $past(rd_take); endproperty
    a_dout: assert property (p_dout) else $error("read data moved without read");
    property p_dsr; rd_take && io_addr_i[0] |=> data_o[7] == !$past(dsr_n_i); endproperty
    a_dsr: assert property (p_dsr) else $error("status bit 7 wrong");
    property p_modem; $changed({dtr_n_o, rts_n_o}) |-> $past(wr_take && io_addr_i[0]); endproperty
    a_modem: assert property (p_modem) else $error("modem outputs moved without command");
    c_rx: cover property ($rose(rx_char_waiting_o));
    c_syn: cover property ($rose(sync_found_o));
    c_drn: cover property ($rose(tx_drained_o));
endmodule // usr_usart_assertions

bind usr_usart usr_usart_assertions u_usr_usart_assertions (.ref_clk_i, .reset_i, .io_addr_i, .io_write_n_i,
    .io_read_n_i, .cts_n_i, .dsr_n_i, .data_o, .data_oe_o, .dtr_n_o, .rts_n_o, .tx_slot_free_o,
    .rx_char_waiting_o, .tx_drained_o, .sync_found_o);

/* File: tb/usr_modem.sv */
// far-end terminal model: bit clock, serial sender and frame catcher
`timescale 1ns/1ns
module usr_modem #(parameter int HALF = 32) (
    input wire logic txd_i,
    output logic bit_clk_o,
    output logic rxd_o
);
    initial begin
        bit_clk_o = 1'h0;
        rxd_o = 1'h1;
    end
    // the rate clock runs free, as a board rate generator does
    always #HALF bit_clk_o = ~bit_clk_o;
    // bits leave lsb first, each held fac clock periods, then the line idles marking
    task automatic send(input logic [10:0] bits, input int n, input int fac);
        for (int i = 0; i < n; i++) begin
            @(negedge bit_clk_o);
            rxd_o = bits[i];
            repeat (fac - 1) @(negedge bit_clk_o);
        end
        @(negedge bit_clk_o);
        rxd_o = 1'h1;
        repeat (2 * fac) @(negedge bit_clk_o);
    endtask
    task automatic glitch(input int n);
        @(negedge bit_clk_o);
        rxd_o = 1'h0;
        repeat (n) @(negedge bit_clk_o);
        rxd_o = 1'h1;
        repeat (32) @(negedge bit_clk_o);
    endtask
    // catches start, eight data, parity and stop at their centres
    task automatic recv(output logic [10:0] bits, input int fac);
        @(negedge txd_i);
        repeat (fac / 2) @(posedge bit_clk_o);
        for (int i = 0; i < 11; i++) begin
            bits[i] = txd_i;
            repeat (fac) @(posedge bit_clk_o);
        end
    endtask
endmodule // usr_modem

/* File: tb/usr_usart_tb.sv */
// self-checking bench of the serial transceiver
`timescale 1ns/1ns
module usr_usart_tb;
    logic ref_clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic [7:0] io_addr_i = 8'h00;
    logic io_write_n_i = 1'h1;
    logic io_read_n_i = 1'h1;
    logic [7:0] data_i = 8'h00;
    logic cts_n_i = 1'h0;
    logic dsr_n_i = 1'h0;
    logic [7:0] data_o;
    logic data_oe_o, bclk, rxd, txd_o, dtr_n_o, rts_n_o;
    logic tx_slot_free_o, rx_char_waiting_o, tx_drained_o, sync_found_o;
    logic [7:0] st;
    logic [10:0] fr;
    int n;
    int fail_count = 0;
    int checks = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    usr_usart u_usr_usart (.ref_clk_i, .reset_i, .io_addr_i, .io_write_n_i, .io_read_n_i, .data_i, .data_o,
        .data_oe_o, .tx_bit_clock_i(bclk), .rx_bit_clock_i(bclk), .rxd_i(rxd), .txd_o, .cts_n_i, .dsr_n_i,
        .dtr_n_o, .rts_n_o, .tx_slot_free_o, .rx_char_waiting_o, .tx_drained_o, .sync_found_o);
    usr_modem u_usr_modem (.txd_i(txd_o), .bit_clk_o(bclk), .rxd_o(rxd));
    // ----------------------------------------
    // host port and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        io_addr_i <= a;
        data_i <= d;
        io_write_n_i <= 1'h0;
        @(posedge ref_clk_i);
        io_write_n_i <= 1'h1;
        @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        io_addr_i <= a;
        io_read_n_i <= 1'h0;
        @(posedge ref_clk_i);
        io_read_n_i <= 1'h1;
        @(posedge ref_clk_i);
        d = data_o;
    endtask
    task automatic lows(input int c, output int k);
        k = 0;
        repeat (c) begin
            @(posedge ref_clk_i);
            k += !txd_o;
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_setup();
        chk(16'({txd_o, tx_slot_free_o, rx_char_waiting_o, tx_drained_o, sync_found_o, dtr_n_o, rts_n_o}),
            16'h43);
        wr(8'hED, 8'h7E);
        wr(8'hED, 8'h27);
        chk(16'({dtr_n_o, rts_n_o}), 16'h0);
        rd(8'hED, st);
        chk(16'({st[7], st[0]}), 16'h3);
    endtask
    task automatic t_tx();
        fork
            u_usr_modem.recv(fr, 16);
            wr(8'hEC, 8'hA5);
        join
        chk(16'(fr), 16'({1'h1, 1'h0, 8'hA5, 1'h0}));
        @(posedge ref_clk_i);
        cts_n_i <= 1'h1;
        wr(8'hEC, 8'h5A);
        lows(400, n);
        chk(n[15:0], 16'h0);
        chk(16'(tx_slot_free_o), 16'h0);
        fork
            u_usr_modem.recv(fr, 16);
            begin
                @(posedge ref_clk_i);
                cts_n_i <= 1'h0;
            end
        join
        chk(16'(fr), 16'({1'h1, 1'h0, 8'h5A, 1'h0}));
        chk(16'(tx_slot_free_o), 16'h1);
    endtask
    task automatic t_break_cs();
        wr(8'hED, 8'h2F);
        lows(20, n);
        chk(n[15:0], 16'h14);
        wr(8'hED, 8'h27);
        lows(20, n);
        chk(n[15:0], 16'h0);
        wr(8'hF1, 8'h00);
        chk(16'(dtr_n_o), 16'h0);
        rd(8'hEF, st);
        chk(16'(st[7]), 16'h1);
    endtask
    task automatic t_rx();
        u_usr_modem.send({1'h1, 1'h1, 8'h3C, 1'h0}, 11, 16);
        rd(8'hED, st);
        chk(16'(st[5:3]), 16'h1);
        u_usr_modem.send({1'h0, 1'h0, 8'h3C, 1'h0}, 11, 16);
        rd(8'hED, st);
        chk(16'(st[5:3]), 16'h7);
        rd(8'hEC, st);
        chk(16'(st), 16'h3C);
        wr(8'hED, 8'h37);
        rd(8'hED, st);
        chk(16'(st[5:3]), 16'h0);
        u_usr_modem.glitch(3);
        u_usr_modem.send({1'h1, 1'h0, 8'h81, 1'h0}, 11, 16);
        chk(16'(rx_char_waiting_o), 16'h1);
        rd(8'hEC, st);
        chk(16'(st), 16'h81);
        chk(16'(rx_char_waiting_o), 16'h0);
    endtask
    task automatic t_sync();
        wr(8'hED, 8'h40);
        chk(16'({dtr_n_o, rts_n_o, tx_slot_free_o}), 16'h6);
        wr(8'hED, 8'h8C);
        wr(8'hED, 8'h16);
        wr(8'hED, 8'h87);
        chk(16'(dtr_n_o), 16'h0);
        lows(200, n);
        chk(n[15:0], 16'h0);
        u_usr_modem.send({3'h7, 8'h16}, 8, 1);
        chk(16'(sync_found_o), 16'h1);
        rd(8'hED, st);
        chk(16'({st[6], sync_found_o}), 16'h2);
        wr(8'hED, 8'h87);
        u_usr_modem.send({3'h7, 8'h16}, 8, 1);
        chk(16'(sync_found_o), 16'h1);
        wr(8'hEC, 8'h55);
        for (int i = 0; i < 400 && tx_drained_o !== 1'h1; i++) @(posedge ref_clk_i);
        chk(16'(tx_drained_o), 16'h1);
        wr(8'hEC, 8'h55);
        chk(16'(tx_drained_o), 16'h0);
    endtask
    task automatic results();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_i);
        reset_i <= 1'h0;
        @(posedge ref_clk_i);
        t_setup();
        t_tx();
        t_break_cs();
        t_rx();
        t_sync();
        results();
    end
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        fail_count++;
        results();
    end
endmodule // usr_usart_tb
